// File: rtl/lfs_frame_sequencer.sv
// lfs_frame_sequencer: apb register file, frame timing, per-frame latching
// and pin drive registers of a segment lcd controller.
// assumes: apb master on pclk; sleep_mode and sys_clk_rc come from the
// power manager on pclk; timer_osc_pin is asynchronous.
//
// Our own choices: the register offsets and register access over APB.

// Overview of operation
// R1: display memory, blanking, waveform and contrast are latched only at frames.
// R2: registers are writable at any time; software updates right after the latch.
// R3: waveform select set gives the low-power waveform instead of default.
// R4: low-power mode latches data and sets the flag every second frame.
// R5: blanking completes the frame then grounds all pins, memory kept.
// R6: software blanks the display before disabling the controller.
// R7: masked segment pins and unused common pins return to port use.
// R8: synchronous clock keeps the display running in idle and power-save.
// R9: async clock with rc system clock runs in idle, adc and power-save.
// R10: external clock option with async select enables the pin input buffer.
// R11: software disables the controller before deep sleep with sync clock.
// R12: software sets rate, duty, bias, mask and contrast before enabling.
// R13: software disables the controller before reconfiguring it.
// R14: disable returns pins to port use; software keeps them low or tristate.
// R15: writing one clears the flag; disable sequence blanks over one frame.
// R16: two-common displays may use half or third bias.
// R17: each frame addresses common zero first then each used common in turn.
// R18: flag is set with the data latch; interrupt when its enable is set.
// R19: duty field picks static, half, third, quarter; static uses static bias.
// R20: a one in memory drives segment opposite to its common.
// R21: polarity reverses so every segment sees no average dc voltage.
module lfs_frame_sequencer (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [11:0]         paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                timer_osc_pin,
	input  wire lfs_pkg::lfs_sleep_t sleep_mode,
	input  wire logic                sys_clk_rc,
	output logic      [79:0]         seg_level,
	output logic      [39:0]         seg_drive_en,
	output logic      [7:0]          com_level,
	output logic      [3:0]          com_drive_en,
	output logic                     frame_irq,
	output logic      [3:0]          contrast_out,
	output logic                     ext_clk_buf_en
);

	logic [7:0]  ctrl_a, next_ctrl_a;
	logic [7:0]  ctrl_b, next_ctrl_b;
	logic [7:0]  frame_rate, next_frame_rate;
	logic [7:0]  contrast_reg, next_contrast_reg;
	logic [7:0]  clock_ctrl, next_clock_ctrl;
	logic [31:0] display_mem [lfs_pkg::MEM_WORDS];
	logic [31:0] next_display_mem [lfs_pkg::MEM_WORDS];
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr;
	logic        acc, done, wr_lane0, mem_hit, mapped, clear_flag;
	logic [31:0] rd_word, status_word;

	logic        controller_enable, low_power_wave_sel, start_of_frame_flag;
	logic        frame_irq_enable, blank_display, async_clock_sel;
	logic        half_bias_sel, ext_clock_input_en;
	logic [1:0]  duty_select;
	logic [3:0]  port_mask, contrast_setting;

	logic [31:0] lat_mem [lfs_pkg::MEM_WORDS];
	logic [31:0] next_lat_mem [lfs_pkg::MEM_WORDS];
	logic        lat_blank, next_lat_blank, lat_lp, next_lat_lp;
	logic [3:0]  lat_contrast, next_lat_contrast;
	logic        running, next_running, started, next_started;
	logic        half_phase, next_half_phase, frame_odd, next_frame_odd;
	logic [1:0]  com_idx, next_com_idx;
	logic        clk_ok, base_tick, ps_tick;
	logic        frame_end, frame_start, latch_now;
	logic        osc_meta, osc_sync, osc_prev;

	logic [79:0] wf_seg_level;
	logic [39:0] wf_seg_drive_en;
	logic [7:0]  wf_com_level;
	logic [3:0]  wf_com_drive_en;
	logic [39:0] seg_row;

	assign controller_enable   = ctrl_a[lfs_pkg::CA_ENABLE_BIT];
	assign low_power_wave_sel  = ctrl_a[lfs_pkg::CA_LOW_PWR_BIT];
	assign start_of_frame_flag = ctrl_a[lfs_pkg::CA_FLAG_BIT];
	assign frame_irq_enable    = ctrl_a[lfs_pkg::CA_IRQ_EN_BIT];
	assign blank_display       = ctrl_a[lfs_pkg::CA_BLANK_BIT];
	assign async_clock_sel     = ctrl_b[lfs_pkg::CB_ASYNC_BIT];
	assign half_bias_sel       = ctrl_b[lfs_pkg::CB_HALF_BIAS];
	assign duty_select         = ctrl_b[lfs_pkg::CB_DUTY_LSB +: 2];
	assign port_mask           = ctrl_b[lfs_pkg::CB_MASK_LSB +: 4];
	assign contrast_setting    = contrast_reg[3:0];
	assign ext_clock_input_en  = clock_ctrl[lfs_pkg::CK_EXT_CLK_BIT];

	////////////////////////////////////////////////////////////////////////
	// apb slave and register file: one wait state, writes at completion

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[lfs_pkg::ST_RUN_BIT] = running;
		status_word[lfs_pkg::ST_BLANK_BIT] = lat_blank;
		status_word[lfs_pkg::ST_HALF_BIT] = half_phase;
		status_word[lfs_pkg::ST_ODD_BIT] = frame_odd;
		status_word[lfs_pkg::ST_COM_LSB +: 2] = com_idx;
		mem_hit = paddr[11:5] == lfs_pkg::OFF_DISP_MEM[11:5];
		mapped = (paddr[1:0] == 2'h0)
			&& (paddr <= lfs_pkg::OFF_STATUS || mem_hit);
		unique case (paddr)
			lfs_pkg::OFF_CTRL_A:     rd_word = {24'h0, ctrl_a};
			lfs_pkg::OFF_CTRL_B:     rd_word = {24'h0, ctrl_b};
			lfs_pkg::OFF_FRAME_RATE: rd_word = {24'h0, frame_rate};
			lfs_pkg::OFF_CONTRAST:   rd_word = {24'h0, contrast_reg};
			lfs_pkg::OFF_CLOCK_CTRL: rd_word = {24'h0, clock_ctrl};
			lfs_pkg::OFF_STATUS:     rd_word = status_word;
			default:                 rd_word = display_mem[paddr[4:2]];
		endcase
		acc = psel && penable;
		done = acc && pready && mapped;
		wr_lane0 = done && pwrite && pstrb[0];
		next_pready = acc && !pready; // [R2]
		next_pslverr = acc && !pready && !mapped;
		next_prdata = prdata;
		if (acc && !pready)
			next_prdata = (mapped && !pwrite) ? rd_word : 32'h0000_0000;
		next_ctrl_a = ctrl_a;
		next_ctrl_b = ctrl_b;
		next_frame_rate = frame_rate;
		next_contrast_reg = contrast_reg;
		next_clock_ctrl = clock_ctrl;
		if (wr_lane0) begin
			unique case (paddr)
				lfs_pkg::OFF_CTRL_A: next_ctrl_a =
					(ctrl_a & ~lfs_pkg::CTRL_A_WMASK)
					| (pwdata[7:0] & lfs_pkg::CTRL_A_WMASK);
				lfs_pkg::OFF_CTRL_B: next_ctrl_b =
					pwdata[7:0] & lfs_pkg::CTRL_B_WMASK;
				lfs_pkg::OFF_FRAME_RATE: next_frame_rate =
					pwdata[7:0] & lfs_pkg::FRAME_RATE_WMASK;
				lfs_pkg::OFF_CONTRAST: next_contrast_reg =
					pwdata[7:0] & lfs_pkg::CONTRAST_WMASK;
				lfs_pkg::OFF_CLOCK_CTRL: next_clock_ctrl =
					pwdata[7:0] & lfs_pkg::CLOCK_CTRL_WMASK;
				default: ;
			endcase
		end
		clear_flag = wr_lane0 && (paddr == lfs_pkg::OFF_CTRL_A)
			&& pwdata[lfs_pkg::CA_FLAG_BIT];
		// a data latch in the clearing cycle keeps the flag set
		next_ctrl_a[lfs_pkg::CA_FLAG_BIT] = latch_now // [R18]
			|| (start_of_frame_flag && !clear_flag); // [R15]
		for (int w = 0; w < lfs_pkg::MEM_WORDS; w++) begin
			next_display_mem[w] = display_mem[w];
			for (int b = 0; b < 4; b++)
				if (done && pwrite && mem_hit && pstrb[b]
					&& paddr[4:2] == 3'(w))
					next_display_mem[w][8*b +: 8] = pwdata[8*b +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a <= lfs_pkg::CTRL_A_RST;
			ctrl_b <= lfs_pkg::CTRL_B_RST;
			frame_rate <= lfs_pkg::FRAME_RATE_RST;
			contrast_reg <= lfs_pkg::CONTRAST_RST;
			clock_ctrl <= lfs_pkg::CLOCK_CTRL_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			for (int w = 0; w < lfs_pkg::MEM_WORDS; w++)
				display_mem[w] <= 32'h0000_0000;
		end else begin
			ctrl_a <= next_ctrl_a;
			ctrl_b <= next_ctrl_b;
			frame_rate <= next_frame_rate;
			contrast_reg <= next_contrast_reg;
			clock_ctrl <= next_clock_ctrl;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			display_mem <= next_display_mem;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer oscillator pin synchroniser and edge detect

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
		end else begin
			osc_meta <= timer_osc_pin;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
		end
	end

	// count and drive only after the first latch, so the first half slot
	// is as long as the rest and carries latched data
	lfs_prescaler u_prescaler (
		.pclk         (pclk),
		.presetn      (presetn),
		.clear        (!started),
		.base_tick    (base_tick),
		.prescale_sel (frame_rate[lfs_pkg::FR_PRESCALE_LSB +: 3]),
		.clk_div      (frame_rate[lfs_pkg::FR_DIV_LSB +: 3]),
		.ps_tick      (ps_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// frame sequencer and per-frame latches

	always_comb begin
		if (async_clock_sel)
			clk_ok = (sleep_mode == lfs_pkg::SLP_ACTIVE) || (sys_clk_rc // [R9]
				&& sleep_mode inside {lfs_pkg::SLP_IDLE,
				lfs_pkg::SLP_ADC_NR, lfs_pkg::SLP_POWER_SAVE});
		else
			clk_ok = sleep_mode inside {lfs_pkg::SLP_ACTIVE, // [R8]
				lfs_pkg::SLP_IDLE, lfs_pkg::SLP_POWER_SAVE};
		next_running = controller_enable && clk_ok; // [R14]
		base_tick = async_clock_sel ? (osc_sync && !osc_prev) : 1'b1;
		frame_end = running && started && ps_tick && half_phase
			&& (com_idx == duty_select);
		frame_start = running && (!started || frame_end);
		next_started = running;
		next_frame_odd = frame_odd;
		if (!running)
			next_frame_odd = 1'b0;
		else if (frame_start)
			next_frame_odd = started ? !frame_odd : 1'b0; // [R21]
		latch_now = frame_start
			&& (!low_power_wave_sel || !next_frame_odd); // [R4]
		next_half_phase = half_phase;
		next_com_idx = com_idx;
		if (!running) begin
			next_half_phase = 1'b0;
			next_com_idx = 2'h0;
		end else if (started && ps_tick) begin
			next_half_phase = !half_phase;
			if (half_phase) // [R17]
				next_com_idx = (com_idx == duty_select) ? 2'h0
					: com_idx + 2'h1;
		end
		next_lat_mem = lat_mem;
		next_lat_blank = lat_blank;
		next_lat_lp = lat_lp;
		next_lat_contrast = lat_contrast;
		if (latch_now) begin // [R1]
			next_lat_mem = display_mem;
			next_lat_blank = blank_display; // [R5]
			next_lat_lp = low_power_wave_sel; // [R3]
			next_lat_contrast = contrast_setting;
		end
		seg_row = {lat_mem[{com_idx, 1'b1}][7:0], lat_mem[{com_idx, 1'b0}]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
			started <= 1'b0;
			frame_odd <= 1'b0;
			half_phase <= 1'b0;
			com_idx <= 2'h0;
			lat_blank <= 1'b0;
			lat_lp <= 1'b0;
			lat_contrast <= 4'h0;
			for (int w = 0; w < lfs_pkg::MEM_WORDS; w++)
				lat_mem[w] <= 32'h0000_0000;
		end else begin
			running <= next_running;
			started <= next_started;
			frame_odd <= next_frame_odd;
			half_phase <= next_half_phase;
			com_idx <= next_com_idx;
			lat_blank <= next_lat_blank;
			lat_lp <= next_lat_lp;
			lat_contrast <= next_lat_contrast;
			lat_mem <= next_lat_mem;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive and side outputs, all registered

	lfs_waveform u_waveform (
		.duty         (duty_select),
		.half_bias    (half_bias_sel),
		.low_power    (lat_lp),
		.frame_odd    (frame_odd),
		.half_phase   (half_phase),
		.com_idx      (com_idx),
		.seg_row      (seg_row),
		.blank        (lat_blank),
		.active       (running && started), // [R21]
		.seg_used     (lfs_pkg::SEG_COUNT[port_mask]),
		.seg_level    (wf_seg_level),
		.seg_drive_en (wf_seg_drive_en),
		.com_level    (wf_com_level),
		.com_drive_en (wf_com_drive_en)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_level <= 80'h0;
			seg_drive_en <= 40'h0;
			com_level <= 8'h00;
			com_drive_en <= 4'h0;
			frame_irq <= 1'b0;
			contrast_out <= 4'h0;
			ext_clk_buf_en <= 1'b0;
		end else begin
			seg_level <= wf_seg_level;
			seg_drive_en <= wf_seg_drive_en;
			com_level <= wf_com_level;
			com_drive_en <= wf_com_drive_en;
			frame_irq <= start_of_frame_flag && frame_irq_enable; // [R18]
			contrast_out <= lat_contrast;
			ext_clk_buf_en <= ext_clock_input_en && async_clock_sel; // [R10]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence apb_wait_s;
		psel && penable && !pready;
	endsequence
	sequence flag_clear_s;
		clear_flag && !latch_now;
	endsequence

	AST_APB_ANSWER: assert property (apb_wait_s |=> pready) // [R2]
		else $error("apb access not answered after one wait");
	AST_LATCH_MEM: assert property ( // [R1]
		latch_now |=> lat_mem[0] == $past(display_mem[0]))
		else $error("display memory not latched at frame start");
	AST_FLAG_SET: assert property (latch_now |=> start_of_frame_flag) // [R18]
		else $error("frame flag not set at latch");
	AST_FLAG_CLEAR: assert property ( // [R15]
		flag_clear_s |=> !start_of_frame_flag)
		else $error("frame flag not cleared by write of one");
	AST_LP_SKIP: assert property ( // [R4]
		frame_start && started && low_power_wave_sel && !frame_odd
		|-> !latch_now)
		else $error("low power mode latched on odd frame");
	AST_BLANK: assert property ( // [R5]
		running && lat_blank |=> seg_level == 80'h0 && com_level == 8'h00)
		else $error("blanked display not grounded");
	AST_OFF_PORT: assert property ( // [R14]
		!controller_enable |-> ##2 seg_drive_en == 40'h0
		&& com_drive_en == 4'h0)
		else $error("pins still driven after disable");
	AST_UNUSED_COM: assert property ( // [R7]
		duty_select == 2'h0 |=> com_drive_en[3:1] == 3'h0)
		else $error("unused common pins driven in static duty");
	AST_SYNC_SLEEP: assert property ( // [R8]
		controller_enable && !async_clock_sel && sleep_mode inside
		{lfs_pkg::SLP_IDLE, lfs_pkg::SLP_POWER_SAVE} |=> running)
		else $error("display stopped in idle or power save");
	AST_FIRST_COM: assert property (frame_start |=> com_idx == 2'h0) // [R17]
		else $error("frame did not start on common zero");
	AST_POLARITY: assert property ( // [R21]
		frame_end |=> frame_odd != $past(frame_odd))
		else $error("frame polarity did not reverse");

endmodule

// File: rtl/lfs_pkg.sv
// lfs_pkg: register map, field positions, reset values and encodings
// of the lcd frame sequencer.
// assumes: shared by the sequencer top, its prescaler and its waveform
// decoder; nothing here holds logic.
package lfs_pkg;

	localparam int NUM_SEG   = 40;
	localparam int NUM_COM   = 4;
	localparam int MEM_WORDS = 8;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] OFF_CTRL_A     = 12'h000;
	localparam logic [11:0] OFF_CTRL_B     = 12'h004;
	localparam logic [11:0] OFF_FRAME_RATE = 12'h008;
	localparam logic [11:0] OFF_CONTRAST   = 12'h00c;
	localparam logic [11:0] OFF_CLOCK_CTRL = 12'h010;
	localparam logic [11:0] OFF_STATUS     = 12'h014;
	localparam logic [11:0] OFF_DISP_MEM   = 12'h020;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CA_ENABLE_BIT   = 7;
	localparam int CA_LOW_PWR_BIT  = 6;
	localparam int CA_FLAG_BIT     = 4;
	localparam int CA_IRQ_EN_BIT   = 3;
	localparam int CA_BLANK_BIT    = 0;
	localparam int CB_ASYNC_BIT    = 7;
	localparam int CB_HALF_BIAS    = 6;
	localparam int CB_DUTY_LSB     = 4;
	localparam int CB_MASK_LSB     = 0;
	localparam int FR_PRESCALE_LSB = 4;
	localparam int FR_DIV_LSB      = 0;
	localparam int CK_EXT_CLK_BIT  = 0;
	localparam int ST_RUN_BIT      = 0;
	localparam int ST_BLANK_BIT    = 1;
	localparam int ST_HALF_BIT     = 2;
	localparam int ST_ODD_BIT      = 3;
	localparam int ST_COM_LSB      = 4;

	////////////////////////////////////////////////////////////////////////
	// reset values and writable bits
	localparam logic [7:0] CTRL_A_RST       = 8'h00;
	localparam logic [7:0] CTRL_B_RST       = 8'h00;
	localparam logic [7:0] FRAME_RATE_RST   = 8'h00;
	localparam logic [7:0] CONTRAST_RST     = 8'h00;
	localparam logic [7:0] CLOCK_CTRL_RST   = 8'h00;
	localparam logic [7:0] CTRL_A_WMASK     = 8'hc9;
	localparam logic [7:0] CTRL_B_WMASK     = 8'hff;
	localparam logic [7:0] FRAME_RATE_WMASK = 8'h77;
	localparam logic [7:0] CONTRAST_WMASK   = 8'h0f;
	localparam logic [7:0] CLOCK_CTRL_WMASK = 8'h01;

	////////////////////////////////////////////////////////////////////////
	// encodings
	typedef enum logic [1:0] {
		DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER
	} lfs_duty_t;

	typedef enum logic [2:0] {
		SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR, SLP_POWER_DOWN, SLP_POWER_SAVE,
		SLP_STANDBY
	} lfs_sleep_t;

	// pin drive levels: ground, 1/3 (or 1/2), 2/3, full lcd voltage
	localparam logic [1:0] LVL_GND  = 2'h0;
	localparam logic [1:0] LVL_LOW  = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] LVL_VLCD = 2'h3;

	// segments in use for each port mask setting
	localparam logic [5:0] SEG_COUNT [16] = '{
		6'h0d, 6'h0f, 6'h11, 6'h13, 6'h15, 6'h17, 6'h18, 6'h19,
		6'h1b, 6'h1d, 6'h1f, 6'h21, 6'h23, 6'h25, 6'h27, 6'h28
	};

	// top counter bit for /16 .. /4096
	localparam logic [3:0] PRESCALE_TAP [8] = '{
		4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb
	};

endpackage

// File: rtl/lfs_prescaler.sv
// lfs_prescaler: 12-bit prescale counter and divide-by-1..8 stage.
// assumes: base_tick is a one-cycle enable on pclk; clear holds it idle.
module lfs_prescaler (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clear,
	input  wire logic       base_tick,
	input  wire logic [2:0] prescale_sel,
	input  wire logic [2:0] clk_div,
	output logic            ps_tick
);

	logic [11:0] cnt;
	logic [11:0] next_cnt;
	logic [2:0]  div_cnt;
	logic [2:0]  next_div_cnt;
	logic [11:0] tap_mask;
	logic        tap_hit;

	always_comb begin
		tap_mask = 12'((13'h0002 << lfs_pkg::PRESCALE_TAP[prescale_sel])
			- 13'h0001);
		tap_hit = base_tick && ((cnt & tap_mask) == tap_mask);
		ps_tick = tap_hit && (div_cnt == clk_div);
		next_cnt = cnt;
		next_div_cnt = div_cnt;
		if (clear) begin
			next_cnt = 12'h000;
			next_div_cnt = 3'h0;
		end else begin
			if (base_tick)
				next_cnt = cnt + 12'h001;
			if (tap_hit)
				next_div_cnt = ps_tick ? 3'h0 : div_cnt + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 12'h000;
			div_cnt <= 3'h0;
		end else begin
			cnt <= next_cnt;
			div_cnt <= next_div_cnt;
		end
	end

endmodule

// File: rtl/lfs_waveform.sv
// lfs_waveform: turns duty, bias, polarity and one row of latched segment
// data into drive levels and drive enables for every pin.
// assumes: purely combinational; the top registers every output.
module lfs_waveform (
	input  wire logic [1:0]   duty,
	input  wire logic         half_bias,
	input  wire logic         low_power,
	input  wire logic         frame_odd,
	input  wire logic         half_phase,
	input  wire logic [1:0]   com_idx,
	input  wire logic [39:0]  seg_row,
	input  wire logic         blank,
	input  wire logic         active,
	input  wire logic [5:0]   seg_used,
	output logic      [79:0]  seg_level,
	output logic      [39:0]  seg_drive_en,
	output logic      [7:0]   com_level,
	output logic      [3:0]   com_drive_en
);

	logic       pol;
	logic [1:0] sel_lvl;
	logic [1:0] unsel_lvl;
	logic [1:0] on_lvl;
	logic [1:0] off_lvl;

	always_comb begin
		// default flips inside each slot, low power once per frame
		pol = low_power ? frame_odd : half_phase; // [R3] [R21]
		sel_lvl = pol ? lfs_pkg::LVL_VLCD : lfs_pkg::LVL_GND;
		on_lvl = pol ? lfs_pkg::LVL_GND : lfs_pkg::LVL_VLCD; // [R20]
		if (duty == 2'(lfs_pkg::DUTY_STATIC)) begin // [R19]
			unsel_lvl = sel_lvl;
			off_lvl = sel_lvl;
		end else if (half_bias) begin // [R16]
			unsel_lvl = lfs_pkg::LVL_LOW;
			off_lvl = lfs_pkg::LVL_LOW;
		end else begin
			unsel_lvl = pol ? lfs_pkg::LVL_LOW : lfs_pkg::LVL_HIGH;
			off_lvl = pol ? lfs_pkg::LVL_HIGH : lfs_pkg::LVL_LOW;
		end
	end

	for (genvar k = 0; k < lfs_pkg::NUM_COM; k++) begin : g_com
		assign com_drive_en[k] = active && (2'(k) <= duty); // [R7]
		assign com_level[2*k +: 2] = blank ? lfs_pkg::LVL_GND : // [R5]
			((2'(k) == com_idx) ? sel_lvl : unsel_lvl); // [R17]
	end

	for (genvar i = 0; i < lfs_pkg::NUM_SEG; i++) begin : g_seg
		assign seg_drive_en[i] = active && (6'(i) < seg_used); // [R7]
		assign seg_level[2*i +: 2] = blank ? lfs_pkg::LVL_GND : // [R5]
			(seg_row[i] ? on_lvl : off_lvl); // [R20]
	end

endmodule

// File: testbench/lfs_panel_model.sv
// lfs_panel_model: one glass cell, segment 0 over common 0, that sums the
// voltage across it every pclk cycle in which segment 0 is driven.
// assumes: pin levels come registered on pclk from the sequencer.
module lfs_panel_model (
	input  wire logic       pclk,
	input  wire logic [1:0] seg_lvl,
	input  wire logic       seg_en,
	input  wire logic [1:0] com_lvl,
	output int              dc_sum
);
	timeunit 1ns;
	timeprecision 1ns;
	int sum = 0;
	assign dc_sum = sum;
	// a lit cell sees opposite phase; charge must cancel over whole frames
	always @(posedge pclk) begin
		if (seg_en === 1'b1)
			sum <= sum + int'(seg_lvl) - int'(com_lvl);
	end
endmodule

// File: testbench/tb_lcd_frame_sequencer.sv
// tb_lcd_frame_sequencer: register table loop, then frame, blanking,
// low-power and disable sequences against one panel cell.
// assumes: apb slave may insert wait states; 16 pclk per prescaled tick.
module tb_lcd_frame_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] x;} lfs_row_t;
	logic                pclk = 1'b0, presetn = 1'b0;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]         paddr = '0;
	logic [31:0]         pwdata = '0, prdata, rd;
	logic                pready, pslverr, err, frame_irq, ext_clk_buf_en;
	logic                sys_clk_rc = 1'b0;
	lfs_pkg::lfs_sleep_t sleep_mode = lfs_pkg::SLP_ACTIVE;
	logic [79:0]         seg_level;
	logic [39:0]         seg_drive_en;
	logic [7:0]          com_level;
	logic [3:0]          com_drive_en, contrast_out;
	int                  num_errors = 0, n_tests = 0, dc_sum;
	lfs_row_t            rows [6] = '{
		'{12'h010, 32'hffffffff, 32'h00000001},
		'{12'h004, 32'h000000ff, 32'h000000ff},
		'{12'h008, 32'h000000ff, 32'h00000077},
		'{12'h00c, 32'h000000ff, 32'h0000000f},
		'{12'h000, 32'h00000026, 32'h00000000},
		'{12'h024, 32'h12345678, 32'h12345678}};

	always #20 pclk = ~pclk;

	lfs_frame_sequencer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_osc_pin(1'b0), .sleep_mode(sleep_mode),
		.sys_clk_rc(sys_clk_rc),
		.seg_level(seg_level), .seg_drive_en(seg_drive_en),
		.com_level(com_level), .com_drive_en(com_drive_en),
		.frame_irq(frame_irq), .contrast_out(contrast_out),
		.ext_clk_buf_en(ext_clk_buf_en));

	lfs_panel_model panel_u (.pclk(pclk), .seg_lvl(seg_level[1:0]),
		.seg_en(seg_drive_en[0]), .com_lvl(com_level[1:0]), .dc_sum(dc_sum));

	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request stands until the edge that samples pready high
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic chk(input logic [79:0] s, input logic [79:0] x);
		n_tests++;
		if (s !== x) begin
			num_errors++;
			$display("Error %0t: seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic wait_flag;
		for (int i = 0; i < 100; i++) begin
			apb(12'h000, 1'b0, '0);
			if (rd[4] === 1'b1)
				break;
		end
	endtask

	task automatic end_of_test;
		$display("errors %0d of %0d compares", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].a < 12'h020) begin
				apb(rows[i].a, 1'b0, '0);
				chk(rd, 32'h0);
			end
			apb(rows[i].a, 1'b1, rows[i].w);
			apb(rows[i].a, 1'b0, '0);
			chk(rd, rows[i].x);
		end
		chk(ext_clk_buf_en, 1'b1);
		apb(12'h018, 1'b0, '0);
		chk({err, rd}, {1'b1, 32'h0});
		apb(12'h004, 1'b1, 32'h3f);
		apb(12'h008, 1'b1, 32'h0);
		apb(12'h020, 1'b1, 32'h1);
		apb(12'h024, 1'b1, 32'h0);
		chk({ext_clk_buf_en, contrast_out}, 5'h00);
		apb(12'h000, 1'b1, 32'h80);
		sleep_mode <= lfs_pkg::SLP_POWER_SAVE;
		repeat (4) @(posedge pclk);
		chk({com_drive_en, seg_drive_en}, {4'hf, 40'hffffffffff});
		chk(contrast_out, 4'hf);
		apb(12'h000, 1'b0, '0);
		chk({frame_irq, rd}, {1'b0, 32'h90});
		apb(12'h000, 1'b1, 32'h98);
		apb(12'h000, 1'b0, '0);
		chk(rd, 32'h88);
		wait_flag();
		chk(frame_irq, 1'b1);
		apb(12'h000, 1'b1, 32'h91);
		wait_flag();
		repeat (3) @(posedge pclk);
		chk({seg_level, com_level}, '0);
		chk(dc_sum, 0);
		apb(12'h020, 1'b0, '0);
		chk(rd, 32'h1);
		apb(12'h000, 1'b1, 32'hd0);
		wait_flag();
		apb(12'h000, 1'b1, 32'hd0);
		repeat (200) @(posedge pclk);
		apb(12'h000, 1'b0, '0);
		chk(rd[4], 1'b0);
		apb(12'h000, 1'b1, 32'h0);
		sleep_mode <= lfs_pkg::SLP_POWER_DOWN;
		repeat (3) @(posedge pclk);
		chk({com_drive_en, seg_drive_en}, '0);
		// reset after disable and power-down clears registers and latched contrast
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(12'h004, 1'b0, '0);
		chk({rd, contrast_out}, '0);
		// async clock with rc system clock keeps running in adc sleep
		apb(12'h004, 1'b1, 32'hbf);
		sleep_mode <= lfs_pkg::SLP_ADC_NR;
		sys_clk_rc <= 1'b1;
		apb(12'h000, 1'b1, 32'h80);
		apb(12'h014, 1'b0, '0);
		chk(rd[0], 1'b1);
		sys_clk_rc <= 1'b0;
		apb(12'h014, 1'b0, '0);
		chk(rd[0], 1'b0);
		end_of_test();
	end
endmodule
